// file: design/ssrc_ctrl.sv
// host controller sequencing zero, full-scale and input ramp measurements
//
// Overview of operation
// - drive three-bit channel select code to pick the converted input
// - keep ramp start low at least the acquisition time before raising
// - time from ramp start rise to ramp stop fall is the result
// - ideal count is input over reference times 256
// - correct by subtracting zero count, scaling 256, dividing by span
// - multiply by 256 done as left shift by eight bits
// - counter increments until ramp stop falls, stops on that falling edge
// - binary timer started at ramp start, ended by ramp stop fall
// - only five lines: three selects, ramp start out, ramp stop in
`timescale 1ns/10ps
`include "ssrc_params.svh"
module ssrc_ctrl #(
  parameter int ACQ_CYCLES     = `SSRC_ACQ_CYCLES,
  parameter int TIMEOUT_CYCLES = `SSRC_TIMEOUT_CYC
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    start,
  input  wire logic [2:0]              channel_in,
  input  wire logic                    ramp_stop,
  output logic [2:0]                   channel_select_code,
  output logic                         ramp_start,
  output logic                         busy,
  output logic                         done,
  output logic                         timeout_err,
  output logic [`SSRC_CNT_W-1:0]       raw_count,
  output logic [`SSRC_RES_W-1:0]       result
);
  localparam int DIV_W = `SSRC_CNT_W + `SSRC_SCALE_SHIFT;

  ssrc_pkg::ssrc_state_type state_r, state_nxt;
  logic [1:0]             phase_r, phase_nxt;
  logic [2:0]             user_ch_r, user_ch_nxt;
  logic [2:0]             sel_r, sel_nxt;
  logic                   rs_r, rs_nxt;
  logic                   stop_d_r;
  logic [`SSRC_CNT_W-1:0] tmr_r, tmr_nxt;
  logic                   busy_r, busy_nxt;
  logic                   done_r, done_nxt;
  logic                   err_r, err_nxt;
  logic [`SSRC_CNT_W-1:0] raw_r, raw_nxt;
  logic [`SSRC_RES_W-1:0] res_r, res_nxt;
  logic [DIV_W-1:0]       num_r, num_nxt;
  logic [DIV_W-1:0]       quo_r, quo_nxt;
  logic [DIV_W-1:0]       den_r, den_nxt;
  logic                   wr_en;
  logic [`SSRC_CNT_W-1:0] zero_q, full_q, raw_q;

  // channel for each measurement phase: ground, reference, then user input
  function automatic logic [2:0] phase_channel(input logic [1:0] ph, input logic [2:0] uc);
    case (ph)
      2'h0:    phase_channel = `SSRC_CH_ZERO;
      2'h1:    phase_channel = `SSRC_CH_FULL;
      default: phase_channel = uc;
    endcase
  endfunction

  // falling edge of ramp stop, seen on registered sample
  wire stop_fall = stop_d_r && !ramp_stop;

  ssrc_count_mem u_mem (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr_en   (wr_en),
    .wr_addr (phase_r),
    .wr_data (tmr_r),
    .zero_q  (zero_q),
    .full_q  (full_q),
    .raw_q   (raw_q)
  );

  always_comb begin
    state_nxt   = state_r;
    phase_nxt   = phase_r;
    user_ch_nxt = user_ch_r;
    sel_nxt     = sel_r;
    rs_nxt      = rs_r;
    tmr_nxt     = tmr_r;
    busy_nxt    = busy_r;
    done_nxt    = 1'b0;
    err_nxt     = err_r;
    raw_nxt     = raw_r;
    res_nxt     = res_r;
    num_nxt     = num_r;
    quo_nxt     = quo_r;
    den_nxt     = den_r;
    wr_en       = 1'b0;
    case (state_r)
      ssrc_pkg::SSRC_IDLE: begin
        if (start) begin
          user_ch_nxt = channel_in;
          phase_nxt   = 2'h0;
          sel_nxt     = phase_channel(2'h0, channel_in);
          rs_nxt      = 1'b0;
          tmr_nxt     = '0;
          busy_nxt    = 1'b1;
          err_nxt     = 1'b0;
          state_nxt   = ssrc_pkg::SSRC_ACQ;
        end
      end
      ssrc_pkg::SSRC_ACQ: begin
        // hold ramp start low for the full acquisition window
        if (tmr_r >= `SSRC_CNT_W'(ACQ_CYCLES - 1)) begin
          rs_nxt    = 1'b1;
          tmr_nxt   = '0;
          state_nxt = ssrc_pkg::SSRC_RAMP;
        end else begin
          tmr_nxt = tmr_r + `SSRC_CNT_W'(1);
        end
      end
      ssrc_pkg::SSRC_RAMP: begin
        // count while ramp stop high, end at its fall
        if (stop_fall && rs_r && tmr_r != '0) begin
          wr_en     = 1'b1;
          rs_nxt    = 1'b0;
          state_nxt = ssrc_pkg::SSRC_NEXT;
        end else if (tmr_r >= `SSRC_CNT_W'(TIMEOUT_CYCLES - 1)) begin
          err_nxt   = 1'b1;
          rs_nxt    = 1'b0;
          busy_nxt  = 1'b0;
          done_nxt  = 1'b1;
          state_nxt = ssrc_pkg::SSRC_IDLE;
        end else begin
          tmr_nxt = tmr_r + `SSRC_CNT_W'(1);
        end
      end
      ssrc_pkg::SSRC_NEXT: begin
        tmr_nxt = '0;
        if (phase_r == 2'h2) begin
          state_nxt = ssrc_pkg::SSRC_DIV;
          phase_nxt = 2'h3;
        end else begin
          phase_nxt = phase_r + 2'h1;
          sel_nxt   = phase_channel(phase_r + 2'h1, user_ch_r);
          state_nxt = ssrc_pkg::SSRC_ACQ;
        end
      end
      ssrc_pkg::SSRC_DIV: begin
        // one cycle to let memory outputs settle, then load divider
        if (phase_r == 2'h3) begin
          phase_nxt = 2'h2;
        end else if (tmr_r == '0) begin
          raw_nxt = raw_q;
          // shift by eight is the scale by 256, half divisor rounds
          // no rounding term when the span falls back to a divisor of one
          num_nxt = (DIV_W'(raw_q > zero_q ? raw_q - zero_q : '0)
                     << `SSRC_SCALE_SHIFT)
                    + ((full_q > zero_q) ? (DIV_W'(full_q - zero_q) >> 1) : DIV_W'(0));
          den_nxt = DIV_W'(full_q > zero_q ? full_q - zero_q : `SSRC_CNT_W'(1));
          quo_nxt = '0;
          tmr_nxt = `SSRC_CNT_W'(1);
        end else if (num_r >= den_r && quo_r <= DIV_W'(8'hFF)) begin
          // repeated subtraction keeps the divider small at the cost of time;
          // stopping past full scale bounds the time for a tiny span
          num_nxt = num_r - den_r;
          quo_nxt = quo_r + DIV_W'(1);
        end else begin
          res_nxt   = (quo_r > DIV_W'(8'hFF)) ? 8'hFF : quo_r[`SSRC_RES_W-1:0];
          state_nxt = ssrc_pkg::SSRC_DONE;
        end
      end
      ssrc_pkg::SSRC_DONE: begin
        busy_nxt  = 1'b0;
        done_nxt  = 1'b1;
        tmr_nxt   = '0;
        state_nxt = ssrc_pkg::SSRC_IDLE;
      end
      default: state_nxt = ssrc_pkg::SSRC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ssrc_pkg::SSRC_IDLE;
      phase_r   <= 2'h0;
      user_ch_r <= 3'h0;
      sel_r     <= 3'h0;
      rs_r      <= 1'b0;
      stop_d_r  <= 1'b0;
      tmr_r     <= '0;
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      err_r     <= 1'b0;
      raw_r     <= '0;
      res_r     <= '0;
      num_r     <= '0;
      quo_r     <= '0;
      den_r     <= '0;
    end else begin
      state_r   <= state_nxt;
      phase_r   <= phase_nxt;
      user_ch_r <= user_ch_nxt;
      sel_r     <= sel_nxt;
      rs_r      <= rs_nxt;
      stop_d_r  <= ramp_stop;
      tmr_r     <= tmr_nxt;
      busy_r    <= busy_nxt;
      done_r    <= done_nxt;
      err_r     <= err_nxt;
      raw_r     <= raw_nxt;
      res_r     <= res_nxt;
      num_r     <= num_nxt;
      quo_r     <= quo_nxt;
      den_r     <= den_nxt;
    end
  end

  // five device lines only; no bus to the converter
  assign channel_select_code = sel_r;
  assign ramp_start          = rs_r;
  assign busy                = busy_r;
  assign done                = done_r;
  assign timeout_err         = err_r;
  assign raw_count           = raw_r;
  assign result              = res_r;
endmodule

// file: design/ssrc_params.svh
// timing and scale constants for the ramp converter controller
`ifndef SSRC_PARAMS_SVH
`define SSRC_PARAMS_SVH
`define SSRC_CLK_HZ        10000000
`define SSRC_ACQ_TIME_US   350
`define SSRC_ACQ_CYCLES    ((`SSRC_ACQ_TIME_US * `SSRC_CLK_HZ + 999999) / 1000000)
`define SSRC_TIMEOUT_US    2000
`define SSRC_TIMEOUT_CYC   ((`SSRC_TIMEOUT_US * `SSRC_CLK_HZ) / 1000000)
`define SSRC_CNT_W         16
`define SSRC_CH_ZERO       3'h0
`define SSRC_CH_FULL       3'h7
`define SSRC_SCALE_SHIFT   8
`define SSRC_RES_W         8
`define SSRC_NUM_SLOTS     3
`endif

// file: design/ssrc_pkg.sv
// types for the ramp converter controller
package ssrc_pkg;
  typedef enum logic [2:0] {
    SSRC_IDLE  = 3'b000,
    SSRC_ACQ   = 3'b001,
    SSRC_RAMP  = 3'b010,
    SSRC_NEXT  = 3'b011,
    SSRC_DIV   = 3'b100,
    SSRC_DONE  = 3'b101
  } ssrc_state_type;
endpackage

// file: design/ssrc_count_mem.sv
// small store for the zero, full-scale and raw ramp counts
`timescale 1ns/10ps
`include "ssrc_params.svh"
module ssrc_count_mem (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   wr_en,
  input  wire logic [1:0]             wr_addr,
  input  wire logic [`SSRC_CNT_W-1:0] wr_data,
  output logic [`SSRC_CNT_W-1:0]      zero_q,
  output logic [`SSRC_CNT_W-1:0]      full_q,
  output logic [`SSRC_CNT_W-1:0]      raw_q
);
  logic [`SSRC_CNT_W-1:0] mem_r [`SSRC_NUM_SLOTS];
  logic [`SSRC_CNT_W-1:0] mem_nxt [`SSRC_NUM_SLOTS];

  always_comb begin
    for (int i = 0; i < `SSRC_NUM_SLOTS; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (wr_en && (wr_addr < 2'h3)) begin
      mem_nxt[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `SSRC_NUM_SLOTS; i++) begin
        mem_r[i] <= '0;
      end
      zero_q <= '0;
      full_q <= '0;
      raw_q  <= '0;
    end else begin
      for (int i = 0; i < `SSRC_NUM_SLOTS; i++) begin
        mem_r[i] <= mem_nxt[i];
      end
      zero_q <= mem_r[0];
      full_q <= mem_r[1];
      raw_q  <= mem_r[2];
    end
  end
endmodule

// file: tb/ssrc_ctrl_assertions.sv
// concurrent checks on the ramp converter controller ports
`timescale 1ns/10ps
`include "ssrc_params.svh"
module ssrc_ctrl_assertions #(
  parameter int ACQ_CYCLES     = 4,
  parameter int TIMEOUT_CYCLES = 200
) (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic                  ramp_stop,
  input wire logic [2:0]            channel_select_code,
  input wire logic                  ramp_start,
  input wire logic                  busy,
  input wire logic                  done,
  input wire logic                  timeout_err,
  input wire logic [`SSRC_RES_W-1:0] result
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  int low_cnt;
  int high_cnt;
  // run lengths of each ramp start level, saturating is not needed at these sizes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt  <= 0;
      high_cnt <= 0;
    end else begin
      low_cnt  <= ramp_start ? 0 : low_cnt + 1;
      high_cnt <= ramp_start ? high_cnt + 1 : 0;
    end
  end
  chk_acq_long: assert property ($rose(ramp_start) |-> low_cnt >= ACQ_CYCLES)
    else $error("ramp start raised before acquisition time");
  chk_sel_hold: assert property (ramp_start && $past(ramp_start)
    |-> $stable(channel_select_code))
    else $error("channel select moved during ramp");
  chk_zero_first: assert property ($rose(busy)
    |-> channel_select_code == 3'h0 && !ramp_start)
    else $error("conversion did not begin with zero channel");
  chk_full_second: assert property ($fell(ramp_start) && channel_select_code == 3'h0
    |-> ##[1:3] (channel_select_code == 3'h7 || timeout_err))
    else $error("full scale channel not measured second");
  chk_stop_ends: assert property (ramp_start && $fell(ramp_stop)
    |-> ##[1:3] !ramp_start)
    else $error("ramp not ended after ramp stop fell");
  chk_timeout_bound: assert property (high_cnt <= TIMEOUT_CYCLES + 2)
    else $error("ramp measurement exceeded timeout");
  chk_timeout_done: assert property ($rose(timeout_err) |-> ##[0:3] done)
    else $error("timeout without done pulse");
  chk_done_pulse: assert property (done |-> !busy ##1 !done)
    else $error("done not a single pulse with busy low");
  chk_idle_acquire: assert property (!busy |-> !ramp_start)
    else $error("ramp start high while idle");
  chk_result_done: assert property ($changed(result) |-> ##1 done)
    else $error("result moved without a done pulse");
endmodule
bind ssrc_ctrl ssrc_ctrl_assertions #(.ACQ_CYCLES(ACQ_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES))
  u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .ramp_stop(ramp_stop),
  .channel_select_code(channel_select_code), .ramp_start(ramp_start), .busy(busy),
  .done(done), .timeout_err(timeout_err), .result(result));

// file: tb/ssrc_dev_model.sv
// behavioural model of the ramp converter device on the far side
`timescale 1ns/10ps
module ssrc_dev_model (
  input  wire logic       ref_clk,
  input  wire logic [2:0] channel_select_code,
  input  wire logic       ramp_start,
  input  wire logic       stuck,
  output logic            ramp_stop
);
  int cnt = 0;
  int len;
  // ramp length per routed channel; ground and reference give the span
  always_comb begin
    case (channel_select_code)
      3'h0:    len = 20;
      3'h1:    len = 21;
      3'h2:    len = 45;
      3'h3:    len = 70;
      3'h4:    len = 95;
      3'h5:    len = 119;
      default: len = 120;
    endcase
  end
  // high ramp start advances the ramp count; low ramp start clears it
  always_ff @(posedge ref_clk) cnt <= ramp_start ? cnt + 1 : 0;
  // open collector with pull-up: released means high; stuck models a dead comparator
  assign ramp_stop = stuck || !(ramp_start && cnt >= len);
endmodule

// file: tb/ssrc_ctrl_tb_top.sv
// self-checking bench for the ramp converter controller
`timescale 1ns/10ps
module ssrc_ctrl_tb_top;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       start = 1'b0;
  logic [2:0] channel_in = 3'h0;
  logic       stuck = 1'b0;
  logic       ramp_stop;
  logic [2:0] channel_select_code;
  logic       ramp_start, busy, done, timeout_err;
  logic [15:0] raw_count;
  logic [7:0] result;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  ssrc_ctrl #(.ACQ_CYCLES(4), .TIMEOUT_CYCLES(200)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .start(start), .channel_in(channel_in), .ramp_stop(ramp_stop),
    .channel_select_code(channel_select_code), .ramp_start(ramp_start), .busy(busy),
    .done(done), .timeout_err(timeout_err), .raw_count(raw_count), .result(result));
  ssrc_dev_model u_dev (.ref_clk(ref_clk), .channel_select_code(channel_select_code),
    .ramp_start(ramp_start), .stuck(stuck), .ramp_stop(ramp_stop));
  initial forever #50 ref_clk = ~ref_clk;
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard well above the longest expected run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // start one conversion; optionally poke start again mid-run, which must be ignored
  task automatic convert(input logic [2:0] ch, input logic poke);
    int n;
    @(posedge ref_clk);
    start <= 1'b1;
    channel_in <= ch;
    @(posedge ref_clk);
    start <= 1'b0;
    repeat (10) @(posedge ref_clk);
    if (poke) begin
      start <= 1'b1;
      channel_in <= 3'h4;
      @(posedge ref_clk);
      start <= 1'b0;
    end
    n = 0;
    @(negedge ref_clk);
    while (done !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    cmp8({7'h00, done}, 8'h01, "done pulse");
  endtask
  // raw counts are the model's ramp lengths; ground gives 20, reference 120
  task automatic test_channels();
    logic [7:0] exp [1:6];
    logic [7:0] raw_exp [1:6];
    exp = '{8'h03, 8'h40, 8'h80, 8'hC0, 8'hFD, 8'hFF};
    raw_exp = '{8'h15, 8'h2D, 8'h46, 8'h5F, 8'h77, 8'h78};
    for (int ch = 1; ch <= 6; ch++) begin
      convert(3'(ch), 1'b0);
      cmp8(result, exp[ch], "corrected result");
      cmp8(raw_count[7:0], raw_exp[ch], "raw ramp count");
      cmp8(raw_count[15:8], 8'h00, "raw count upper byte");
      cmp8({7'h00, timeout_err}, 8'h00, "spurious timeout");
    end
    $display("test_channels done");
  endtask
  task automatic test_refuse();
    convert(3'h2, 1'b1);
    cmp8(result, 8'h40, "start taken while busy");
    @(negedge ref_clk);
    cmp8({7'h00, busy, done}, 8'h00, "busy or done after end");
    $display("test_refuse done");
  endtask
  task automatic test_timeout();
    stuck <= 1'b1;
    convert(3'h3, 1'b0);
    cmp8({7'h00, timeout_err}, 8'h01, "timeout flag");
    cmp8(result, 8'h40, "result changed by timeout");
    cmp8(raw_count[7:0], 8'h2D, "raw count changed by timeout");
    stuck <= 1'b0;
    convert(3'h3, 1'b0);
    cmp8({7'h00, timeout_err}, 8'h00, "timeout flag not cleared");
    cmp8(result, 8'h80, "result after recovery");
    $display("test_timeout done");
  endtask
  // reset in mid conversion must clear every output and leave the block ready
  task automatic test_reset();
    @(posedge ref_clk);
    start <= 1'b1;
    channel_in <= 3'h5;
    @(posedge ref_clk);
    start <= 1'b0;
    repeat (30) @(posedge ref_clk);
    rst_n <= 1'b0;
    @(negedge ref_clk);
    cmp8({4'h0, busy, done, ramp_start, timeout_err}, 8'h00, "flags in reset");
    cmp8({5'h00, channel_select_code}, 8'h00, "select in reset");
    cmp8(result | raw_count[7:0] | raw_count[15:8], 8'h00, "counts in reset");
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    convert(3'h3, 1'b0);
    cmp8(result, 8'h80, "result after reset");
    cmp8(raw_count[7:0], 8'h46, "raw count after reset");
    $display("test_reset done");
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_channels();
    test_refuse();
    test_timeout();
    test_reset();
    results();
  end
endmodule
